// ==== design/band_cal_pkg.sv ====
// package: register map, field layout, timing for the band calibration block
package band_cal_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BANK1 = 8'h04;
    localparam logic [7:0] OFF_BANK2 = 8'h08;
    localparam logic [7:0] OFF_READBACK = 8'h0C;
    localparam logic [7:0] OFF_GPO = 8'h10;
    localparam logic [7:0] OFF_ISTAT = 8'h14;
    localparam logic [7:0] OFF_IMASK = 8'h18;
    localparam logic [7:0] OFF_SHARE = 8'h1C;
    // control register fields
    localparam int CTRL_RELOCK = 0;
    localparam int CTRL_KEEPALIVE = 3;
    localparam int CTRL_LODIV_LSB = 8;
    localparam int CTRL_WARMUP_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // interrupt status bits
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    // band limits
    localparam int NUM_BANDS = 128;
    localparam logic [6:0] BAND_LOW = 7'h00;
    localparam logic [6:0] BAND_HIGH = 7'h7F;
    localparam logic [6:0] BAND_MID = 7'h40;
    localparam int NUM_OSC = 3;
    localparam int LODIV_MAX = 32;
    // warm-up: field value times one step
    localparam int WARMUP_STEP_NS = 1000;
    localparam int CLK_NS = 25;
    localparam int WARMUP_STEP_CYC = (WARMUP_STEP_NS + CLK_NS - 1) / CLK_NS;
    // oscillator settling per band step
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int NUM_GPO = 6;
    localparam int NUM_DEV = 4;
    localparam logic [1:0] BRESP_OK = 2'h0;
    localparam logic [1:0] BRESP_ERR = 2'h2;
endpackage

// ==== design/sync3.sv ====
// three-stage pin synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ps
module sync3 (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pin in, filtered level out
    input wire logic pinIn,
    output logic levelOut
);
    logic s1_r, s2_r, s3_r, lvl_r;
    logic lvl_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        if (s2_r == s3_r) begin
            lvl_nxt = s3_r;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign levelOut = lvl_r;
endmodule

// ==== design/vco_band_cal.sv ====
// top: oscillator and coarse band calibration control with AXI4-Lite regs
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module vco_band_cal
    import band_cal_pkg::*;
#(
    parameter int WARMUP_W = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device pins
    input wire logic powerUpPin,
    input wire logic bankSelectPin,
    input wire logic [1:0] deviceAddrPin,
    // oscillator comparator: high while oscillator runs below target
    input wire logic oscBelowTarget,
    input wire logic lockDetect,
    // analog controls
    output logic [1:0] oscSelect,
    output logic [6:0] bandSelect,
    output logic pllAcquire,
    output logic refPowered,
    output logic corePowered,
    output logic [5:0] loDivRatio,
    output logic [NUM_GPO-1:0] generalOutput,
    output logic irq
);
    typedef enum {ST_OFF, ST_WARM, ST_IDLE, ST_OSC, ST_BAND, ST_LOCK} st_t;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic enLvl, bankLvl;
    sync3 uEn (.clock(clock), .rst(rst), .pinIn(powerUpPin),
        .levelOut(enLvl));
    sync3 uBank (.clock(clock), .rst(rst), .pinIn(bankSelectPin),
        .levelOut(bankLvl));

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl_r, ctrl_nxt, bank1_r, bank1_nxt, bank2_r, bank2_nxt;
    logic [31:0] gpo_r, gpo_nxt;
    logic [1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [1:0] share_r, share_nxt;
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic [7:0] awA_r, awA_nxt;
    logic [31:0] wD_r, wD_nxt;
    logic [3:0] wS_r, wS_nxt;
    logic bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic irq_r, irq_nxt;
    logic [NUM_GPO-1:0] gpoOut_r, gpoOut_nxt;
    logic [5:0] lodiv_r, lodiv_nxt;
    // handshake readies and status pins leave the block from flops
    logic awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt, arRdy_r, arRdy_nxt;
    logic acq_r, acq_nxt, refOn_r, refOn_nxt;

    // calibration state
    st_t st_r, st_nxt;
    logic [1:0] osc_r, osc_nxt;
    logic [6:0] band_r, band_nxt, res_r, res_nxt;
    logic fail_r, fail_nxt, en_d_r, warmed_r, warmed_nxt;
    logic [WARMUP_W+15:0] wcnt_r, wcnt_nxt;
    logic [7:0] scnt_r, scnt_nxt;
    logic evDone, evFail;

    logic doWrite, selMe, relockReq;
    logic [31:0] bankAct, wmask;
    assign doWrite = awHeld_r && wHeld_r && !bv_r;
    // shared bus: with share bit 0 set, a device only applies writes tagged with its own address; every write is answered
    assign selMe = (wD_r[31:30] == deviceAddrPin)
        || share_r[0] == 1'b0;
    assign relockReq = doWrite && selMe && awA_r == OFF_CTRL && wS_r[0]
        && wD_r[CTRL_RELOCK];
    assign bankAct = bankLvl ? bank2_r : bank1_r;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            wmask[i] = wS_r[i/8];
        end
    end

    always_comb begin
        awHeld_nxt = awHeld_r;
        awA_nxt = awA_r;
        wHeld_nxt = wHeld_r;
        wD_nxt = wD_r;
        wS_nxt = wS_r;
        bv_nxt = bv_r && !s_axi_bready;
        br_nxt = br_r;
        rv_nxt = rv_r && !s_axi_rready;
        rr_nxt = rr_r;
        rd_nxt = rd_r;
        ctrl_nxt = ctrl_r;
        ctrl_nxt[CTRL_RELOCK] = 1'b0; // self-clearing
        bank1_nxt = bank1_r;
        bank2_nxt = bank2_r;
        gpo_nxt = gpo_r;
        imask_nxt = imask_r;
        share_nxt = share_r;
        ist_nxt = ist_r;
        if (s_axi_awvalid && !awHeld_r) begin
            awHeld_nxt = 1'b1;
            awA_nxt = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !wHeld_r) begin
            wHeld_nxt = 1'b1;
            wD_nxt = s_axi_wdata;
            wS_nxt = s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = BRESP_OK;
            if (selMe) begin
                case (awA_r)
                    OFF_CTRL: ctrl_nxt = (ctrl_r & ~wmask) | (wD_r & wmask);
                    OFF_BANK1: bank1_nxt = (bank1_r & ~wmask) | (wD_r & wmask);
                    OFF_BANK2: bank2_nxt = (bank2_r & ~wmask) | (wD_r & wmask);
                    OFF_GPO: gpo_nxt = (gpo_r & ~wmask) | (wD_r & wmask);
                    OFF_ISTAT: ist_nxt = ist_r & ~wD_r[1:0];
                    OFF_IMASK: imask_nxt = wD_r[1:0];
                    OFF_SHARE: share_nxt = wD_r[1:0];
                    OFF_READBACK: ;
                    default: br_nxt = BRESP_ERR;
                endcase
                ctrl_nxt[CTRL_RELOCK] = 1'b0;
            end
        end
        // set wins over a write-one clear in the same cycle
        if (evDone) begin
            ist_nxt[EV_DONE] = 1'b1;
        end
        if (evFail) begin
            ist_nxt[EV_FAIL] = 1'b1;
        end
        if (s_axi_arvalid && !rv_r) begin
            rv_nxt = 1'b1;
            rr_nxt = BRESP_OK;
            case ({s_axi_araddr[7:2], 2'b00})
                OFF_CTRL: rd_nxt = ctrl_r;
                OFF_BANK1: rd_nxt = bank1_r;
                OFF_BANK2: rd_nxt = bank2_r;
                OFF_READBACK: rd_nxt = {21'h0, lockDetect, fail_r, osc_r,
                    res_r};
                OFF_GPO: rd_nxt = gpo_r;
                OFF_ISTAT: rd_nxt = {30'h0, ist_r};
                OFF_IMASK: rd_nxt = {30'h0, imask_r};
                OFF_SHARE: rd_nxt = {30'h0, share_r};
                default: begin
                    rd_nxt = 32'h0000_0000;
                    rr_nxt = BRESP_ERR;
                end
            endcase
        end
        irq_nxt = |(ist_nxt & imask_nxt);
        // readies mirror the held flags one edge ahead, so timing is unchanged
        awRdy_nxt = !awHeld_nxt;
        wRdy_nxt = !wHeld_nxt;
        arRdy_nxt = !rv_nxt;
        // divider field 0..31 means ratio 1..32
        lodiv_nxt = {1'b0, ctrl_r[CTRL_LODIV_LSB +: 5]} + 6'h01;
        // bit 8+g for output g picks internal lock instead of the driven level
        for (int g = 0; g < NUM_GPO; g++) begin
            gpoOut_nxt[g] = gpo_r[8+g] ? lockDetect : gpo_r[g];
        end
    end

    // ****************************************
    // calibration sequencer
    // ****************************************
    logic keep, enRise, runAllowed;
    assign keep = ctrl_r[CTRL_KEEPALIVE];
    assign enRise = enLvl && !en_d_r;
    assign runAllowed = enLvl || keep;

    always_comb begin
        st_nxt = st_r;
        osc_nxt = osc_r;
        band_nxt = band_r;
        res_nxt = res_r;
        fail_nxt = fail_r;
        warmed_nxt = warmed_r;
        wcnt_nxt = wcnt_r;
        scnt_nxt = scnt_r;
        evDone = 1'b0;
        evFail = 1'b0;
        case (st_r)
            ST_OFF: begin
                warmed_nxt = 1'b0;
                if (runAllowed) begin
                    st_nxt = ST_WARM;
                    wcnt_nxt = (WARMUP_W+16)'(ctrl_r[CTRL_WARMUP_LSB +:
                        WARMUP_W]) * (WARMUP_W+16)'(WARMUP_STEP_CYC);
                end
            end
            ST_WARM: begin
                if (wcnt_r != '0) begin
                    wcnt_nxt = wcnt_r - 1'b1;
                end else begin
                    warmed_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (enRise || (relockReq && enLvl)) begin
                    st_nxt = ST_OSC;
                end
            end
            ST_OSC: begin
                osc_nxt = (bankAct[1:0] > 2'(NUM_OSC-1)) ? 2'(NUM_OSC-1)
                    : bankAct[1:0];
                band_nxt = BAND_LOW;
                scnt_nxt = 8'(SETTLE_CYC);
                st_nxt = ST_BAND;
            end
            ST_BAND: begin
                if (scnt_r != 8'h00) begin
                    scnt_nxt = scnt_r - 8'h01;
                end else if (oscBelowTarget || band_r == BAND_HIGH) begin
                    res_nxt = band_r;
                    fail_nxt = (band_r == BAND_LOW) ||
                        (band_r == BAND_HIGH);
                    evDone = 1'b1;
                    evFail = (band_r == BAND_LOW) || (band_r == BAND_HIGH);
                    st_nxt = ST_LOCK;
                end else begin
                    band_nxt = band_r + 7'h01;
                    scnt_nxt = 8'(SETTLE_CYC);
                end
            end
            ST_LOCK: begin
                if (relockReq && enLvl) begin
                    st_nxt = ST_OSC;
                end
            end
            default: st_nxt = ST_OFF;
        endcase
        if (st_r != ST_OFF && !runAllowed) begin
            st_nxt = ST_OFF;
        end else if ((st_r == ST_LOCK || st_r == ST_OSC || st_r == ST_BAND)
            && !enLvl) begin
            st_nxt = ST_IDLE;
        end
        if (rst) begin
            st_nxt = ST_OFF;
        end
        acq_nxt = (st_nxt == ST_LOCK);
        refOn_nxt = (st_nxt != ST_OFF);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awA_r <= 8'h00;
            wHeld_r <= 1'b0;
            wD_r <= 32'h0000_0000;
            wS_r <= 4'h0;
            bv_r <= 1'b0;
            br_r <= 2'h0;
            rv_r <= 1'b0;
            rr_r <= 2'h0;
            rd_r <= 32'h0000_0000;
            ctrl_r <= CTRL_RESET;
            bank1_r <= 32'h0000_0000;
            bank2_r <= 32'h0000_0000;
            gpo_r <= 32'h0000_0000;
            ist_r <= 2'h0;
            imask_r <= 2'h0;
            share_r <= 2'h0;
            irq_r <= 1'b0;
            gpoOut_r <= '0;
            lodiv_r <= 6'h01;
            st_r <= ST_OFF;
            osc_r <= 2'h0;
            band_r <= BAND_MID;
            res_r <= 7'h00;
            fail_r <= 1'b0;
            warmed_r <= 1'b0;
            wcnt_r <= '0;
            scnt_r <= 8'h00;
            en_d_r <= 1'b0;
            awRdy_r <= 1'b1;
            wRdy_r <= 1'b1;
            arRdy_r <= 1'b1;
            acq_r <= 1'b0;
            refOn_r <= 1'b0;
        end else begin
            awHeld_r <= awHeld_nxt;
            awA_r <= awA_nxt;
            wHeld_r <= wHeld_nxt;
            wD_r <= wD_nxt;
            wS_r <= wS_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rr_r <= rr_nxt;
            rd_r <= rd_nxt;
            ctrl_r <= ctrl_nxt;
            bank1_r <= bank1_nxt;
            bank2_r <= bank2_nxt;
            gpo_r <= gpo_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            share_r <= share_nxt;
            irq_r <= irq_nxt;
            gpoOut_r <= gpoOut_nxt;
            lodiv_r <= lodiv_nxt;
            st_r <= st_nxt;
            osc_r <= osc_nxt;
            band_r <= band_nxt;
            res_r <= res_nxt;
            fail_r <= fail_nxt;
            warmed_r <= warmed_nxt;
            wcnt_r <= wcnt_nxt;
            scnt_r <= scnt_nxt;
            en_d_r <= enLvl;
            awRdy_r <= awRdy_nxt;
            wRdy_r <= wRdy_nxt;
            arRdy_r <= arRdy_nxt;
            acq_r <= acq_nxt;
            refOn_r <= refOn_nxt;
        end
    end

    assign s_axi_awready = awRdy_r;
    assign s_axi_wready = wRdy_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_arready = arRdy_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rr_r;
    assign oscSelect = osc_r;
    assign bandSelect = band_r;
    assign pllAcquire = acq_r;
    assign refPowered = refOn_r;
    assign corePowered = warmed_r;
    assign loDivRatio = lodiv_r;
    assign generalOutput = gpoOut_r;
    assign irq = irq_r;

    // ****************************************
    // assertions
    // ****************************************
    property p_fail_flag;
        @(posedge clock) disable iff (rst)
        (st_r == ST_BAND && st_nxt == ST_LOCK) |=>
            fail_r == (res_r == BAND_LOW || res_r == BAND_HIGH);
    endproperty
    a_fail_flag: assert property (p_fail_flag)
        else $error("fail flag disagrees with band result");

    property p_success;
        @(posedge clock) disable iff (rst)
        ($rose(pllAcquire) && res_r > 7'h00 && res_r < 7'h7F) |-> !fail_r;
    endproperty
    a_success: assert property (p_success)
        else $error("mid band reported as failure");

    property p_start;
        @(posedge clock) disable iff (rst)
        (st_r == ST_IDLE && enRise && runAllowed) |=> st_r == ST_OSC;
    endproperty
    a_start: assert property (p_start)
        else $error("calibration did not start on power-up rise");

    property p_lock_after;
        @(posedge clock) disable iff (rst)
        $rose(pllAcquire) |-> $past(st_r) == ST_BAND;
    endproperty
    a_lock_after: assert property (p_lock_after)
        else $error("lock acquire before band chosen");

    property p_pdown;
        @(posedge clock) disable iff (rst)
        (!enLvl && !keep) |=> !refPowered;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("no power-down with pin and keep-alive low");

    property p_lodiv;
        @(posedge clock) disable iff (rst)
        1'b1 |=> loDivRatio >= 6'h01 && loDivRatio <= 6'(LODIV_MAX);
    endproperty
    a_lodiv: assert property (p_lodiv)
        else $error("divider out of range");

    property p_band_step;
        @(posedge clock) disable iff (rst)
        (st_r == ST_BAND && st_nxt == ST_BAND && band_nxt != band_r) |=>
            band_r == $past(band_r) + 7'h01;
    endproperty
    a_band_step: assert property (p_band_step)
        else $error("band did not step by one");

    property p_standby;
        @(posedge clock) disable iff (rst)
        (keep && st_r == ST_IDLE && !enLvl) |=> refPowered;
    endproperty
    a_standby: assert property (p_standby)
        else $error("reference dropped in standby");

    property p_osc;
        @(posedge clock) disable iff (rst)
        1'b1 |-> oscSelect <= 2'(NUM_OSC-1);
    endproperty
    a_osc: assert property (p_osc)
        else $error("invalid oscillator index");

    c_done: cover property (@(posedge clock) disable iff (rst)
        $rose(pllAcquire) && !fail_r);
    c_fail: cover property (@(posedge clock) disable iff (rst)
        $rose(fail_r));
    c_relock: cover property (@(posedge clock) disable iff (rst)
        st_r == ST_LOCK && relockReq);
endmodule

// ==== verif/osc_model.sv ====
// oscillator comparator and lock detector facing the calibration block
`timescale 1ns/1ps
module osc_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // from the block
    input wire logic [6:0] bandSelect,
    input wire logic pllAcquire,
    // band at which the bench wants the search to stop
    input wire logic [6:0] targetBand,
    // to the block
    output logic oscBelowTarget,
    output logic lockDetect
);
    logic [2:0] lockCnt_r;
    // each added step lowers the frequency; reached once band meets target
    assign oscBelowTarget = (bandSelect >= targetBand);
    always_ff @(posedge clock) begin
        if (rst || !pllAcquire) begin
            lockCnt_r <= 3'h0;
        end else if (lockCnt_r != 3'h7) begin
            lockCnt_r <= lockCnt_r + 3'h1;
        end
    end
    // the loop cannot settle before the block lets it acquire
    assign lockDetect = (lockCnt_r == 3'h7);
endmodule

// ==== verif/testbench.sv ====
// testbench for the band calibration block: AXI4-Lite host and pin driver
`timescale 1ns/1ps
module testbench;
    import band_cal_pkg::*;
    // ****
    // signals
    // ****
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic powerUpPin = 1'b0;
    logic bankSelectPin = 1'b0;
    logic [1:0] deviceAddrPin = 2'h2;
    logic oscBelowTarget;
    logic lockDetect;
    logic [1:0] oscSelect;
    logic [6:0] bandSelect;
    logic pllAcquire;
    logic refPowered;
    logic corePowered;
    logic [5:0] loDivRatio;
    logic [5:0] generalOutput;
    logic irq;
    logic [6:0] targetBand = 7'h00;
    logic [31:0] rdv;
    logic [1:0] resp;
    int fails = 0;
    int nCompared = 0;
    int cycles = 0;

    vco_band_cal vco_band_cal_i (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .powerUpPin(powerUpPin),
        .bankSelectPin(bankSelectPin), .deviceAddrPin(deviceAddrPin),
        .oscBelowTarget(oscBelowTarget), .lockDetect(lockDetect),
        .oscSelect(oscSelect), .bandSelect(bandSelect),
        .pllAcquire(pllAcquire), .refPowered(refPowered),
        .corePowered(corePowered), .loDivRatio(loDivRatio),
        .generalOutput(generalOutput), .irq(irq)
    );
    osc_model osc_model_i (
        .clock(clock), .rst(rst), .bandSelect(bandSelect),
        .pllAcquire(pllAcquire), .targetBand(targetBand),
        .oscBelowTarget(oscBelowTarget), .lockDetect(lockDetect)
    );

    always #12.5 clock = ~clock;
    // a full run needs under 10000 cycles; the ceiling leaves ample margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            conclude();
        end
    end
    // ****
    // shared tasks
    // ****
    task automatic conclude();
        if (fails == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                rdv = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        chk(bandSelect, BAND_MID);
        chk(loDivRatio, 6'h01);
        chk(refPowered, 1'b0);
        chk(irq, 1'b0);
        rd(OFF_CTRL);
        chk(rdv, CTRL_RESET);
    endtask
    task automatic t_warmup();
        // keep-alive on, warm-up field of one step
        wr(OFF_CTRL, 32'h0001_0008);
        repeat (30) @(posedge clock);
        chk(corePowered, 1'b0);
        chk(refPowered, 1'b1);
        repeat (20) @(posedge clock);
        chk(corePowered, 1'b1);
    endtask
    task automatic t_lodiv();
        wr(OFF_CTRL, 32'h0001_1F08);
        repeat (2) @(posedge clock);
        chk(loDivRatio, 6'h20);
        wr(OFF_CTRL, 32'h0001_0008);
        repeat (2) @(posedge clock);
        chk(loDivRatio, 6'h01);
    endtask
    task automatic t_cal(input logic usePin, input logic [6:0] tgt,
                         input logic [1:0] osc);
        logic failExp;
        failExp = (tgt == 7'h00) || (tgt == 7'h7F);
        targetBand <= tgt;
        wr(OFF_ISTAT, 32'h0000_0003);
        if (usePin) begin
            powerUpPin <= 1'b0;
            repeat (6) @(posedge clock);
            powerUpPin <= 1'b1;
            repeat (5) @(posedge clock);
        end else begin
            // host re-runs the search at an unchanged frequency, as on drift
            wr(OFF_CTRL, 32'h0001_0009);
        end
        chk(pllAcquire, 1'b0);
        rdv = 32'h0;
        while (rdv[EV_DONE] !== 1'b1)
            rd(OFF_ISTAT);
        chk(rdv[1:0], {failExp, 1'b1});
        rd(OFF_READBACK);
        chk(rdv[6:0], tgt);
        chk(rdv[8:7], osc);
        chk(rdv[9], failExp);
        chk(oscSelect, osc);
        chk(bandSelect, tgt);
        repeat (3) @(posedge clock);
        chk(pllAcquire, 1'b1);
    endtask
    task automatic t_share();
        wr(OFF_SHARE, 32'h8000_0001);
        // foreign device address: dropped, yet answered OKAY
        wr(OFF_GPO, 32'h4000_002A);
        chk(resp, BRESP_OK);
        chk(generalOutput, 6'h00);
        // output 0 follows lock, the rest are plain levels
        wr(OFF_GPO, 32'h8000_0114);
        repeat (2) @(posedge clock);
        chk(generalOutput, 6'h15);
        wr(OFF_SHARE, 32'h8000_0000);
    endtask
    task automatic t_unmapped();
        wr(8'h20, 32'h1234_5678);
        chk(resp, BRESP_ERR);
        rd(8'h20);
        chk(resp, BRESP_ERR);
        chk(rdv, 32'h0);
    endtask
    task automatic t_power();
        powerUpPin <= 1'b0;
        repeat (8) @(posedge clock);
        chk(refPowered, 1'b1);
        wr(OFF_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clock);
        chk(refPowered, 1'b0);
        chk(corePowered, 1'b0);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_warmup();
        t_lodiv();
        wr(OFF_BANK1, 32'h0000_0001);
        wr(OFF_BANK2, 32'h0000_0003);
        wr(OFF_IMASK, 32'h0000_0000);
        t_cal(1'b1, 7'h25, 2'h1);
        chk(irq, 1'b0);
        wr(OFF_IMASK, 32'h0000_0003);
        repeat (3) @(posedge clock);
        chk(irq, 1'b1);
        wr(OFF_ISTAT, 32'h0000_0003);
        repeat (3) @(posedge clock);
        chk(irq, 1'b0);
        bankSelectPin <= 1'b1;
        repeat (6) @(posedge clock);
        t_cal(1'b0, 7'h00, 2'h2);
        t_cal(1'b0, 7'h01, 2'h2);
        t_cal(1'b0, 7'h7E, 2'h2);
        t_cal(1'b0, 7'h7F, 2'h2);
        rd(OFF_CTRL);
        chk(rdv[CTRL_RELOCK], 1'b0);
        t_share();
        t_unmapped();
        t_power();
        conclude();
    end
endmodule
